// ==== design/dal_lock_ctrl.sv ====
// top: sample clock source selection, lock handling, mute and status monitor
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
// Operation
// - source is link, internal 48k or 44.1k
// - internal source keeps digital input disabled
// - report measured rate and pro/consumer format
// - retry lock until acquired on first select
// - interruption mutes, falls back to last rate
// - relock setting governs retry after interruption
// - lock loss or data payload mutes, errors
// - rate beyond 4 percent flags and mutes
// - three error classes, each mutes input
// - status monitor always updated, even internal
// - monitor shows rate, format, emphasis flags
// - after loss show no-lock and fallback rate
// - relock on retries; off waits for reselect
module dal_lock_ctrl #(
   parameter int unsigned RETRY_CYCLES = dal_pkg::RETRY_CYC
) (
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   // register port
   input  wire logic [3:0]       addr_i,
   input  wire logic [7:0]       wdata_i,
   input  wire logic             wr_i,
   input  wire logic             rd_i,
   output logic      [7:0]       rdata_o,
   // link receiver report
   input  wire dal_pkg::dal_rx_s rx_i,
   // to the audio path and clocking
   output logic                  acq_start_o,
   output logic                  dig_mute_o,
   output logic                  use_link_clk_o,
   output logic                  int_48k_o,
   output logic                  irq_o,
   output dal_pkg::dal_stat_s    status_o
);
   typedef enum logic [3:0] {
      ST_INT    = 4'b0001,
      ST_ACQ    = 4'b0010,
      ST_LOCKED = 4'b0100,
      ST_FALL   = 4'b1000
   } dal_state_e;

   dal_state_e                     state_reg;
   logic [7:0]                     ctrl_reg;
   logic [dal_pkg::EV_W-1:0]       ev_reg;
   logic [dal_pkg::EV_W-1:0]       en_reg;
   logic [dal_pkg::EV_W-1:0]       ev_set;
   logic [5:0]                     rx_s1_reg;
   logic [5:0]                     rx_s2_reg;
   dal_pkg::dal_rx_s               rx;
   logic                           frame_d_reg;
   logic                           frame_pulse;
   logic                           sel_pulse;
   logic [31:0]                    retry_reg;
   logic                           retry_tick;
   logic                           meas_done;
   logic [dal_pkg::GATE_W-1:0]     meas_cyc;
   dal_pkg::dal_rate_e             meas_rate;
   dal_pkg::dal_rate_e             last_rate_reg;
   logic                           range_ok_reg;
   logic                           measured_reg;
   logic                           link_sel;
   logic                           audio_ok;

   // ==========================================================
   // helpers
   function automatic logic in_band(input logic [dal_pkg::GATE_W-1:0] c,
                                    input int unsigned nom, input int unsigned tol);
      in_band = (32'(c) + tol >= nom) && (32'(c) <= nom + tol);
   endfunction : in_band

   function automatic dal_pkg::dal_rate_e classify(input logic [dal_pkg::GATE_W-1:0] c);
      if (in_band(c, dal_pkg::NOM_48K_CYC, dal_pkg::TOL_48K_CYC)) begin
         classify = dal_pkg::DAL_RATE_48K;
      end else if (in_band(c, dal_pkg::NOM_44K1_CYC, dal_pkg::TOL_44K1_CYC)) begin
         classify = dal_pkg::DAL_RATE_44K1;
      end else begin
         classify = dal_pkg::DAL_RATE_NONE;
      end
   endfunction : classify

   // ==========================================================
   // receiver inputs come from the link domain: two flops each
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_s1_reg   <= '0;
         rx_s2_reg   <= '0;
         frame_d_reg <= 1'b0;
      end else begin
         rx_s1_reg   <= rx_i;
         rx_s2_reg   <= rx_s1_reg;
         frame_d_reg <= rx_s2_reg[5];
      end
   end

   assign rx          = rx_s2_reg;
   // frame arrives as a level pulse per frame; its rising edge is taken after the synchroniser
   assign frame_pulse = rx.frame & ~frame_d_reg;

   // ==========================================================
   // register writes
   assign sel_pulse = wr_i && (addr_i == dal_pkg::REG_CTRL);
   assign link_sel  = (ctrl_reg[dal_pkg::CTRL_SRC_LSB +: 2] == dal_pkg::SRC_LINK);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_reg <= dal_pkg::CTRL_RESET_VAL;
         en_reg   <= '0;
      end else if (wr_i) begin
         if (addr_i == dal_pkg::REG_CTRL) begin
            ctrl_reg <= {5'h00, wdata_i[2:0]};
         end
         if (addr_i == dal_pkg::REG_EV_EN) begin
            en_reg <= wdata_i[dal_pkg::EV_W-1:0];
         end
      end
   end

   // ==========================================================
   // rate measurement
   dal_rate_meter u_meter (
      .clock_i  (clock_i),
      .rst_n_i  (rst_n_i),
      .run_i    (rx.locked),
      .frame_i  (frame_pulse),
      .done_o   (meas_done),
      .cycles_o (meas_cyc)
   );

   assign meas_rate = classify(meas_cyc);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         range_ok_reg  <= 1'b0;
         measured_reg  <= 1'b0;
         last_rate_reg <= dal_pkg::DAL_RATE_48K;
      end else if (!rx.locked) begin
         measured_reg <= 1'b0;
      end else if (meas_done) begin
         measured_reg <= 1'b1;
         range_ok_reg <= (meas_rate != dal_pkg::DAL_RATE_NONE);
         if (meas_rate != dal_pkg::DAL_RATE_NONE && !rx.non_audio) begin
            last_rate_reg <= meas_rate;
         end
      end
   end

   // valid audio: lock, a measured in-tolerance rate and an audio payload
   assign audio_ok = rx.locked && measured_reg && range_ok_reg && !rx.non_audio;

   // ==========================================================
   // retry pacing
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         retry_reg <= '0;
      end else if (state_reg != ST_ACQ || retry_tick || sel_pulse) begin
         // a reselect restarts pacing so no retry strobe directly follows its strobe
         retry_reg <= '0;
      end else begin
         retry_reg <= retry_reg + 32'h1;
      end
   end

   assign retry_tick = (retry_reg == 32'(RETRY_CYCLES - 1));

   // ==========================================================
   // lock state machine
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg   <= ST_INT;
         acq_start_o <= 1'b0;
      end else begin
         acq_start_o <= 1'b0;
         if (!link_sel) begin
            state_reg <= ST_INT;
         end else if (sel_pulse) begin
            // reselecting the link restarts acquisition from scratch
            state_reg   <= ST_ACQ;
            acq_start_o <= 1'b1;
         end else begin
            unique case (state_reg)
               ST_INT: begin
                  state_reg   <= ST_ACQ;
                  acq_start_o <= 1'b1;
               end
               ST_ACQ: begin
                  if (audio_ok) begin
                     state_reg <= ST_LOCKED;
                  end else if (retry_tick) begin
                     acq_start_o <= 1'b1;
                  end
               end
               ST_LOCKED: begin
                  if (!rx.locked) begin
                     // relock flag decides retry versus parking on internal clock
                     state_reg <= ctrl_reg[dal_pkg::CTRL_RELOCK] ? ST_ACQ : ST_FALL;
                  end
               end
               ST_FALL: begin
                  // parked on the internal clock; only a control write leaves
                  state_reg <= ST_FALL;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // clocking and mute outputs
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dig_mute_o     <= 1'b1;
         use_link_clk_o <= 1'b0;
         int_48k_o      <= 1'b1;
      end else begin
         // mute one cycle after a fault is seen, release only in lock
         dig_mute_o     <= !(link_sel && state_reg == ST_LOCKED && audio_ok);
         use_link_clk_o <= link_sel && state_reg == ST_LOCKED && rx.locked;
         unique case (ctrl_reg[dal_pkg::CTRL_SRC_LSB +: 2])
            dal_pkg::SRC_INT_48K:  int_48k_o <= 1'b1;
            dal_pkg::SRC_INT_44K1: int_48k_o <= 1'b0;
            default: int_48k_o <= (last_rate_reg != dal_pkg::DAL_RATE_44K1);
         endcase
      end
   end

   // ==========================================================
   // status monitor, refreshed every cycle whatever the source
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_o <= '0;
      end else begin
         status_o.valid        <= audio_ok;
         status_o.no_lock      <= !rx.locked;
         status_o.rate         <= audio_ok ? last_rate_reg
                                  : (int_48k_o ? dal_pkg::DAL_RATE_48K
                                               : dal_pkg::DAL_RATE_44K1);
         status_o.fmt          <= !audio_ok ? dal_pkg::DAL_FMT_NONE
                                  : (rx.pro ? dal_pkg::DAL_FMT_PRF
                                            : dal_pkg::DAL_FMT_CNS);
         // pro streams carry two curves in the code, consumer only one bit
         status_o.emph         <= audio_ok ? (rx.pro ? rx.emph : {1'b0, rx.emph[0]})
                                           : 2'h0;
         status_o.err_lock     <= link_sel && !rx.locked;
         status_o.err_range    <= link_sel && rx.locked && measured_reg
                                  && !range_ok_reg;
         status_o.err_nonaudio <= link_sel && rx.locked && rx.non_audio;
      end
   end

   // ==========================================================
   // events: sticky, set wins over clear
   assign ev_set[dal_pkg::EV_LOCK]     = link_sel && state_reg == ST_LOCKED && !rx.locked;
   assign ev_set[dal_pkg::EV_RANGE]    = link_sel && meas_done && rx.locked
                                         && meas_rate == dal_pkg::DAL_RATE_NONE;
   assign ev_set[dal_pkg::EV_NONAUDIO] = link_sel && rx.locked && rx.non_audio;
   assign ev_set[dal_pkg::EV_RELOCK]   = state_reg == ST_ACQ && audio_ok && link_sel;

   // a clear in the cycle of a new event keeps the bit set
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ev_reg <= '0;
      end else begin
         ev_reg <= ((wr_i && addr_i == dal_pkg::REG_EV_CLR)
                    ? (ev_reg & ~wdata_i[dal_pkg::EV_W-1:0]) : ev_reg) | ev_set;
      end
   end

   // irq looks at this cycle's events too, saving a cycle of latency
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |((ev_reg | ev_set) & en_reg);
      end
   end

   // ==========================================================
   // register reads, one cycle after the strobe
   // unmapped and write-only offsets read back as zero
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         unique case (addr_i)
            dal_pkg::REG_CTRL:   rdata_o <= ctrl_reg;
            dal_pkg::REG_STATUS: rdata_o <= {status_o.err_lock, status_o.err_range,
                                             status_o.err_nonaudio, status_o.no_lock,
                                             status_o.rate, status_o.fmt};
            dal_pkg::REG_EVENTS: rdata_o <= {4'h0, ev_reg};
            dal_pkg::REG_EV_EN:  rdata_o <= {4'h0, en_reg};
            default:             rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule : dal_lock_ctrl

// ==== design/dal_pkg.sv ====
// package: constants, encodings and carriers for the digital input lock control
package dal_pkg;
   // sample clock source selection
   localparam logic [1:0] SRC_LINK     = 2'h0;
   localparam logic [1:0] SRC_INT_48K  = 2'h1;
   localparam logic [1:0] SRC_INT_44K1 = 2'h2;

   // clock
   localparam int unsigned CLK_HZ = 10_000_000;

   // nominal rates in Hz and the tolerance in percent
   localparam int unsigned RATE_48K_HZ   = 48_000;
   localparam int unsigned RATE_44K1_HZ  = 44_100;
   localparam int unsigned RATE_TOL_PCT  = 4;

   // rate measurement gate: one window of link frames counted against core clocks
   localparam int unsigned GATE_FRAMES   = 64;
   localparam int unsigned GATE_W        = 16;
   // expected core cycles per gate at each nominal rate
   localparam int unsigned NOM_48K_CYC   = (CLK_HZ / RATE_48K_HZ) * GATE_FRAMES;
   localparam int unsigned NOM_44K1_CYC  = (CLK_HZ / RATE_44K1_HZ) * GATE_FRAMES;
   localparam int unsigned TOL_48K_CYC   = NOM_48K_CYC * RATE_TOL_PCT / 100;
   localparam int unsigned TOL_44K1_CYC  = NOM_44K1_CYC * RATE_TOL_PCT / 100;

   // lock retry pacing: time between acquisition attempts in microseconds
   localparam int unsigned RETRY_US      = 200;
   localparam int unsigned RETRY_CYC     = RETRY_US * (CLK_HZ / 1_000_000);

   // interrupt status / enable bit positions
   localparam int unsigned EV_LOCK       = 0;
   localparam int unsigned EV_RANGE      = 1;
   localparam int unsigned EV_NONAUDIO   = 2;
   localparam int unsigned EV_RELOCK     = 3;
   localparam int unsigned EV_W          = 4;

   // register offsets
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_EVENTS = 4'h2;
   localparam logic [3:0] REG_EV_CLR = 4'h3;
   localparam logic [3:0] REG_EV_EN  = 4'h4;

   // control field positions
   localparam int unsigned CTRL_SRC_LSB   = 0;
   localparam int unsigned CTRL_RELOCK    = 2;
   localparam logic [7:0]  CTRL_RESET_VAL = 8'h04;

   typedef enum logic [1:0] {
      DAL_FMT_NONE = 2'h0,
      DAL_FMT_CNS  = 2'h1,
      DAL_FMT_PRF  = 2'h2
   } dal_fmt_e;

   typedef enum logic [1:0] {
      DAL_RATE_NONE = 2'h0,
      DAL_RATE_44K1 = 2'h1,
      DAL_RATE_48K  = 2'h2
   } dal_rate_e;

   // one decoded frame report from the link receiver
   typedef struct packed {
      logic       frame;      // high for part of each received frame, rising edge marks it
      logic       locked;     // receiver phase lock
      logic       pro;        // professional channel status
      logic       non_audio;  // payload is data
      logic [1:0] emph;       // emphasis code
   } dal_rx_s;

   // status monitor contents
   typedef struct packed {
      logic      valid;
      logic      no_lock;
      dal_rate_e rate;
      dal_fmt_e  fmt;
      logic [1:0] emph;
      logic       err_lock;
      logic       err_range;
      logic       err_nonaudio;
   } dal_stat_s;
endpackage : dal_pkg

// ==== design/dal_rate_meter.sv ====
// rate meter: times a gate of link frames against the core clock
`timescale 1ns/100ps
module dal_rate_meter #(
   parameter int unsigned GATE = dal_pkg::GATE_FRAMES
) (
   input  wire logic                      clock_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      run_i,
   input  wire logic                      frame_i,
   output logic                           done_o,
   output logic [dal_pkg::GATE_W-1:0]     cycles_o
);
   logic [dal_pkg::GATE_W-1:0] cyc_reg;
   logic [7:0]                 frm_reg;

   // ==========================================================
   // gate counting
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cyc_reg  <= '0;
         frm_reg  <= '0;
         done_o   <= 1'b0;
         cycles_o <= '0;
      end else begin
         done_o <= 1'b0;
         if (!run_i) begin
            cyc_reg <= '0;
            frm_reg <= '0;
         end else begin
            // saturate so a very slow link reads as far out of range, flagging err_range
            if (cyc_reg != '1) begin
               cyc_reg <= cyc_reg + 1'b1;
            end
            if (frame_i) begin
               if (frm_reg == 8'(GATE - 1)) begin
                  done_o   <= 1'b1;
                  cycles_o <= cyc_reg;
                  cyc_reg  <= '0;
                  frm_reg  <= '0;
               end else begin
                  frm_reg <= frm_reg + 1'b1;
               end
            end
         end
      end
   end
endmodule : dal_rate_meter

// ==== verification/dal_link_src.sv ====
// partner: behavioural digital audio link source feeding the receiver report
`timescale 1ns/100ps
module dal_link_src (
   input  wire logic        clock_i,
   input  wire logic [8:0]  period_i,
   input  wire logic        lock_i,
   input  wire logic        pro_i,
   input  wire logic        nonaudio_i,
   input  wire logic [1:0]  emph_i,
   output dal_pkg::dal_rx_s rx_o
);
   logic [8:0] cnt_reg;
   logic       junk_reg = 1'b0;
   // ==============================
   // frame timing: the link stands still while unlocked
   always_ff @(posedge clock_i) begin
      if (!lock_i || cnt_reg >= period_i - 9'h001) begin
         cnt_reg <= 9'h000;
      end else begin
         cnt_reg <= cnt_reg + 9'h001;
      end
   end
   always_ff @(posedge clock_i) junk_reg <= ~junk_reg;
   // status bits mean nothing without lock, so they toggle rather than hold
   always_comb begin
      rx_o.frame     = lock_i && (cnt_reg < {1'b0, period_i[8:1]});
      rx_o.locked    = lock_i;
      rx_o.pro       = lock_i ? pro_i : junk_reg;
      rx_o.non_audio = lock_i ? nonaudio_i : junk_reg;
      rx_o.emph      = lock_i ? emph_i : {junk_reg, ~junk_reg};
   end
endmodule : dal_link_src

// ==== verification/dal_lock_ctrl_checker.sv ====
// checker: port assertions for the digital input lock control
`timescale 1ns/100ps
module dal_lock_ctrl_checker #(
   parameter int unsigned RETRY_CYCLES = dal_pkg::RETRY_CYC
) (
   input wire logic               clock_i,
   input wire logic               rst_n_i,
   input wire logic [3:0]         addr_i,
   input wire logic [7:0]         wdata_i,
   input wire logic               wr_i,
   input wire logic               rd_i,
   input wire logic [7:0]         rdata_o,
   input wire dal_pkg::dal_rx_s   rx_i,
   input wire logic               acq_start_o,
   input wire logic               dig_mute_o,
   input wire logic               use_link_clk_o,
   input wire logic               int_48k_o,
   input wire logic               irq_o,
   input wire dal_pkg::dal_stat_s status_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // ==============================
   // mute and clock source
   property p_int_mute; !use_link_clk_o |-> dig_mute_o; endproperty
   a_int_mute: assert property (p_int_mute) else $error("unmuted on internal clock");
   property p_unmute; !dig_mute_o |-> use_link_clk_o && status_o.valid; endproperty
   a_unmute: assert property (p_unmute) else $error("unmuted without valid lock");
   // sync lag is three cycles, so four cycles of data payload must have muted
   property p_nonaudio; rx_i.non_audio [*4] |-> dig_mute_o; endproperty
   a_nonaudio: assert property (p_nonaudio) else $error("data payload not muted");
   property p_loss; (!rx_i.locked) [*4] |-> dig_mute_o && !use_link_clk_o; endproperty
   a_loss: assert property (p_loss) else $error("lock loss without fallback");
   property p_int44;
      wr_i && addr_i == dal_pkg::REG_CTRL && wdata_i[1:0] == dal_pkg::SRC_INT_44K1
         |-> ##[1:3] (!int_48k_o && !use_link_clk_o);
   endproperty
   a_int44: assert property (p_int44) else $error("44.1k select ignored");
   property p_int48;
      wr_i && addr_i == dal_pkg::REG_CTRL && wdata_i[1:0] == dal_pkg::SRC_INT_48K
         |-> ##[1:3] (int_48k_o && !use_link_clk_o);
   endproperty
   a_int48: assert property (p_int48) else $error("48k select ignored");
   property p_acq; acq_start_o |=> !acq_start_o; endproperty
   a_acq: assert property (p_acq) else $error("acquire strobe too long");
   // ==============================
   // register port
   property p_rd_idle; rdata_o != 8'h00 |-> $past(rd_i); endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_unmapped; rd_i && addr_i > dal_pkg::REG_EV_EN |=> rdata_o == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_stat_rd;
      rd_i && addr_i == dal_pkg::REG_STATUS |=> rdata_o == $past({status_o.err_lock,
         status_o.err_range, status_o.err_nonaudio, status_o.no_lock, status_o.rate,
         status_o.fmt});
   endproperty
   a_stat_rd: assert property (p_stat_rd) else $error("status read mismatch");
endmodule : dal_lock_ctrl_checker

bind dal_lock_ctrl dal_lock_ctrl_checker #(.RETRY_CYCLES(RETRY_CYCLES)) dal_lock_ctrl_checker_inst (
   .clock_i        (clock_i),
   .rst_n_i        (rst_n_i),
   .addr_i         (addr_i),
   .wdata_i        (wdata_i),
   .wr_i           (wr_i),
   .rd_i           (rd_i),
   .rdata_o        (rdata_o),
   .rx_i           (rx_i),
   .acq_start_o    (acq_start_o),
   .dig_mute_o     (dig_mute_o),
   .use_link_clk_o (use_link_clk_o),
   .int_48k_o      (int_48k_o),
   .irq_o          (irq_o),
   .status_o       (status_o)
);

// ==== verification/test_dal_lock_ctrl.sv ====
// testbench: drives registers and a link source, checks mute, fallback and status
`timescale 1ns/100ps
module test_dal_lock_ctrl;
   localparam int unsigned RETRY = 20;
   logic               clock_i, rst_n_i, wr_i, rd_i, rd_d, acq_start_o, dig_mute_o;
   logic               use_link_clk_o, int_48k_o, irq_o, lock, pro, nonaudio;
   logic [3:0]         addr_i;
   logic [7:0]         wdata_i, rdata_o;
   logic [8:0]         period;
   logic [1:0]         emph;
   logic [31:0]        seed;
   logic [7:0]         exp_q[$], msk_q[$];
   dal_pkg::dal_rx_s   rx_i;
   dal_pkg::dal_stat_s status_o;
   int                 miscompares, checks, n, i;

   dal_lock_ctrl #(.RETRY_CYCLES(RETRY)) dal_lock_ctrl_inst (.clock_i(clock_i),
      .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .rx_i(rx_i), .acq_start_o(acq_start_o), .dig_mute_o(dig_mute_o),
      .use_link_clk_o(use_link_clk_o), .int_48k_o(int_48k_o), .irq_o(irq_o),
      .status_o(status_o));
   dal_link_src dal_link_src_inst (.clock_i(clock_i), .period_i(period), .lock_i(lock),
      .pro_i(pro), .nonaudio_i(nonaudio), .emph_i(emph), .rx_o(rx_i));

   // ==============================
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic end_sim();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clock_i);
      wr_i    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clock_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge clock_i);
      rd_i   <= 1'b0;
   endtask : rd
   task automatic settle(input int c);
      repeat (c) @(negedge clock_i);
   endtask : settle
   task automatic wait_mute(input logic v);
      n = 0;
      while (dig_mute_o !== v && n < 40000) begin
         @(negedge clock_i);
         n++;
      end
   endtask : wait_mute
   task automatic count_acq(output int c);
      c = 0;
      repeat (100) begin
         @(negedge clock_i);
         if (acq_start_o === 1'b1) c++;
      end
   endtask : count_acq

   // ==============================
   // read data monitor: read data stand only in the cycle after the strobe
   always @(posedge clock_i) rd_d <= rd_i;
   always @(negedge clock_i) begin
      if (rd_d === 1'b1 && exp_q.size() > 0) begin
         check("rdata", rdata_o & msk_q[0], exp_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end

   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   // runs need about 44k cycles; this allows over half as much again
   initial begin
      #7_000_000;
      miscompares++;
      end_sim();
   end

   initial begin
      rst_n_i = 1'b0;
      addr_i = 4'h0;
      wdata_i = 8'h00;
      wr_i = 1'b0;
      rd_i = 1'b0;
      rd_d = 1'b0;
      period = 9'h0d0;
      lock = 1'b0;
      pro = 1'b0;
      nonaudio = 1'b0;
      emph = 2'h0;
      seed = 32'ha430a66a;
      miscompares = 0;
      checks = 0;
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      check("mute", dig_mute_o, 8'h01);
      check("int48", int_48k_o, 8'h01);
      rd(dal_pkg::REG_CTRL, dal_pkg::CTRL_RESET_VAL, 8'hff);
      for (i = 0; i < 3; i++) begin
         seed = xs(seed);
         wr(4'h5 + 4'(seed[7:0] % 11), seed[15:8]);
         rd(4'h5 + 4'(seed[7:0] % 11), 8'h00, 8'hff);
      end
      $display("test registers done");
      wr(dal_pkg::REG_CTRL, 8'h06);
      settle(4);
      check("int48", int_48k_o, 8'h00);
      check("link", use_link_clk_o, 8'h00);
      check("mute", dig_mute_o, 8'h01);
      wr(dal_pkg::REG_CTRL, 8'h05);
      settle(4);
      check("int48", int_48k_o, 8'h01);
      $display("test internal done");
      @(posedge clock_i);
      lock   <= 1'b1;
      period <= 9'h0fa;
      wr(dal_pkg::REG_CTRL, 8'h04);
      n = 0;
      while (status_o.err_range !== 1'b1 && n < 40000) begin
         @(negedge clock_i);
         n++;
      end
      check("range", status_o.err_range, 8'h01);
      check("mute", dig_mute_o, 8'h01);
      rd(dal_pkg::REG_EVENTS, 8'h02, 8'h02);
      $display("test range done");
      seed = xs(seed);
      @(posedge clock_i);
      period <= 9'h0d0;
      emph   <= seed[1:0];
      wait_mute(1'b0);
      check("mute", dig_mute_o, 8'h00);
      check("link", use_link_clk_o, 8'h01);
      check("rate", status_o.rate, dal_pkg::DAL_RATE_48K);
      check("fmt", status_o.fmt, dal_pkg::DAL_FMT_CNS);
      check("valid", status_o.valid, 8'h01);
      // consumer streams carry a single emphasis flag
      check("emph", status_o.emph, {1'b0, seed[0]});
      $display("test lock done");
      wr(dal_pkg::REG_EV_EN, 8'h05);
      @(posedge clock_i);
      nonaudio <= 1'b1;
      settle(8);
      check("mute", dig_mute_o, 8'h01);
      check("nonaudio", status_o.err_nonaudio, 8'h01);
      check("irq", irq_o, 8'h01);
      @(posedge clock_i);
      lock     <= 1'b0;
      nonaudio <= 1'b0;
      settle(8);
      check("link", use_link_clk_o, 8'h00);
      check("int48", int_48k_o, 8'h01);
      check("nolock", status_o.no_lock, 8'h01);
      check("fallrate", status_o.rate, dal_pkg::DAL_RATE_48K);
      check("errlock", status_o.err_lock, 8'h01);
      count_acq(n);
      check("retry", 8'(n >= 3), 8'h01);
      wr(dal_pkg::REG_EV_EN, 8'h00);
      settle(3);
      check("irq", irq_o, 8'h00);
      wr(dal_pkg::REG_EV_EN, 8'h05);
      settle(3);
      check("irq", irq_o, 8'h01);
      $display("test loss done");
      @(posedge clock_i);
      period <= 9'h0e2;
      pro    <= 1'b1;
      lock   <= 1'b1;
      wr(dal_pkg::REG_CTRL, 8'h00);
      wait_mute(1'b0);
      check("mute", dig_mute_o, 8'h00);
      check("rate", status_o.rate, dal_pkg::DAL_RATE_44K1);
      check("fmt", status_o.fmt, dal_pkg::DAL_FMT_PRF);
      check("emph", status_o.emph, emph);
      wr(dal_pkg::REG_EV_CLR, 8'h0f);
      settle(3);
      check("irq", irq_o, 8'h00);
      rd(dal_pkg::REG_EVENTS, 8'h00, 8'h07);
      @(posedge clock_i);
      lock <= 1'b0;
      settle(8);
      check("mute", dig_mute_o, 8'h01);
      check("int48", int_48k_o, 8'h00);
      check("fallrate", status_o.rate, dal_pkg::DAL_RATE_44K1);
      check("irq", irq_o, 8'h01);
      count_acq(n);
      check("noretry", 8'(n), 8'h00);
      $display("test relock off done");
      end_sim();
   end
endmodule : test_dal_lock_ctrl
